// >>> logic/rwi_pkg.sv
// Constants and types shared by the reset and wake-up initialiser.
// Assumes a single 20 MHz clock and a plain strobe register port.
package rwi_pkg;

   // Register port geometry
   localparam int          ADDR_W        = 6;
   localparam int          DATA_W        = 32;
   localparam int          BYTE_W        = 8;

   // Register byte offsets
   localparam logic [5:0]  OFF_CAUSE     = 6'h00;
   localparam logic [5:0]  OFF_LAT       = 6'h04;
   localparam logic [5:0]  OFF_DIR       = 6'h08;
   localparam logic [5:0]  OFF_PINS      = 6'h0c;
   localparam logic [5:0]  OFF_CFG       = 6'h10;
   localparam logic [5:0]  OFF_FLAG      = 6'h14;
   localparam logic [5:0]  OFF_IRQ_STAT  = 6'h18;
   localparam logic [5:0]  OFF_IRQ_MASK  = 6'h1c;
   localparam logic [5:0]  OFF_TOS       = 6'h20;
   localparam logic [5:0]  OFF_RETURN_STACK_POINTER    = 6'h24;

   // Port field layout
   localparam logic [7:0]  PORT_LOW_IMPL = 8'h1f;
   localparam logic [7:0]  MASK_B5       = 8'h20;
   localparam logic [7:0]  MASK_B67      = 8'hc0;
   localparam logic [7:0]  LATDIR_IMPL   = 8'hdf;
   localparam logic [7:0]  LAT_POR       = 8'h00;
   localparam logic [7:0]  DIR_RST       = 8'hdf;

   // Wake-source flag register: bits 7 and 3 unimplemented
   localparam logic [7:0]  FLAG_IMPL     = 8'h77;
   localparam logic [7:0]  FLAG_RST      = 8'h00;

   // Configuration register
   localparam int          CFG_FREE67    = 0;
   localparam int          CFG_MASTER_CLEAR_PIN_OFF  = 1;
   localparam logic [7:0]  CFG_IMPL      = 8'h03;
   localparam logic [7:0]  CFG_POR       = 8'h00;

   // Program counter, vectors and return stack
   localparam int          PC_W          = 21;
   localparam logic [20:0] VEC_HIGH      = 21'h000008;
   localparam logic [20:0] VEC_LOW       = 21'h000018;
   localparam logic [20:0] TOS_POR       = 21'h000000;
   localparam int          SP_W          = 5;
   localparam logic [4:0]  SP_RST        = 5'h00;
   localparam logic [4:0]  SP_MAX        = 5'h1f;
   localparam logic [4:0]  SP_ONE        = 5'h01;

   // Interrupt status and mask bit positions
   localparam int          IRQ_W         = 4;
   localparam int          IRQ_POR       = 0;
   localparam int          IRQ_SHARED    = 1;
   localparam int          IRQ_WAKE      = 2;
   localparam int          IRQ_VECTOR    = 3;

   typedef enum logic [1:0] {
      CLS_NONE   = 2'b00,
      CLS_POR    = 2'b01,
      CLS_SHARED = 2'b10,
      CLS_WAKE   = 2'b11
   } rwi_class_t;

   typedef enum logic [0:0] {
      ST_LOAD = 1'b0,
      ST_RUN  = 1'b1
   } rwi_state_t;

endpackage

// >>> logic/rwi_init_cell.sv
// One 8-bit register that takes its value from the initialisation class.
// Assumes load is a one-cycle pulse from the sequencer.
`timescale 1ns/10ps
module rwi_init_cell #(
   parameter logic [7:0] POR_VAL     = 8'h00,
   parameter logic [7:0] SHARED_VAL  = 8'h00,
   parameter bit         SHARED_KEEP = 1'b0,
   parameter logic [7:0] IMPL        = 8'hff
) (
   input  logic                ref_clk,
   input  logic                arst_n,
   input  logic                load,
   input  rwi_pkg::rwi_class_t cls,
   input  logic                wr,
   input  logic [7:0]          wdata,
   input  logic [7:0]          set_bits,
   output logic [7:0]          q
);

   typedef struct packed {
      logic [7:0] val;
   } rwi_cell_state_t;

   rwi_cell_state_t cur;
   rwi_cell_state_t next_cur;

   always_comb begin
      next_cur = cur;
      if (load) begin
         case (cls)
            rwi_pkg::CLS_POR:    next_cur.val = POR_VAL;
            rwi_pkg::CLS_SHARED: next_cur.val = SHARED_KEEP ? cur.val
                                                            : SHARED_VAL;
            rwi_pkg::CLS_WAKE:   next_cur.val = cur.val | set_bits; // RQ2 RQ4
            default:             next_cur.val = cur.val;
         endcase
      end else if (wr) begin
         next_cur.val = wdata;
      end
      // Unimplemented bits never hold a one
      next_cur.val = next_cur.val & IMPL; // RQ3
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cur.val <= POR_VAL & IMPL;
      end else begin
         cur <= next_cur;
      end
   end

   assign q = cur.val;

endmodule

// >>> logic/rwi_reset_init.sv
// Reset and wake-up initialiser: picks the init class, loads registers.
// Assumes cause inputs are one-cycle pulses synchronous to ref_clk and
// that arst_n is the power-on reset.
//
// Notes on behaviour
// [RQ1] Power-on/brown-out, the shared reset group and wake-up each load their own value set.
// [RQ2] A wake-up leaves bits marked unchanged at their earlier values.
// [RQ3] Unimplemented bits always read back as zero.
// [RQ4] A wake-up sets the flag bits that name its source.
// [RQ5] An interrupt wake-up with a global enable set loads the vector 0008h or 0018h.
// [RQ6] That wake-up also pushes the program counter to the stack top and bumps the pointer; the code holds the pointer at SP_MAX instead of bumping it.
// [RQ7] Port bits 6 and 7 and their latch and direction exist only when the oscillator frees them.
// [RQ8] Port bit 5 reads as an input only when the master-clear function is off.
// [RQ9] Instruction fetch stays held until the class values are in place.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
module rwi_reset_init (
   input  logic        ref_clk,
   input  logic        arst_n,
   input  logic        bor_rst,
   input  logic        master_clear_pin_rst,
   input  logic        watchdog_timer_rst,
   input  logic        instr_rst,
   input  logic        stack_rst,
   input  logic        wake_watchdog_timer,
   input  logic        wake_irq,
   input  logic        wake_irq_low,
   input  logic [7:0]  wake_src,
   input  logic        high_priority_global_irq_enable,
   input  logic        low_priority_global_irq_enable,
   input  logic [20:0] pc_in,
   input  logic [7:0]  first_port_pins,
   input  logic [5:0]  reg_addr,
   input  logic [31:0] reg_wdata,
   input  logic        reg_wr,
   input  logic        reg_rd,
   output logic [31:0] reg_rdata,
   output logic        fetch_en,
   output logic        pc_load,
   output logic [20:0] pc_vector,
   output logic [4:0]  return_stack_pointer,
   output logic [7:0]  first_port_output_latch,
   output logic [7:0]  first_port_direction,
   output logic        irq
);

   typedef struct packed {
      rwi_pkg::rwi_state_t st;
      rwi_pkg::rwi_class_t cls;
      logic                vec_go;
      logic                vec_low;
      logic [20:0]         pc_cap;
      logic [7:0]          src;
      logic [20:0]         tos;
      logic [4:0]          sp;
      logic                pc_load;
      logic [20:0]         pc_vector;
      logic [3:0]          irq_stat;
      logic [3:0]          irq_mask;
      logic [31:0]         rdata;
   } rwi_state_s_t;

   rwi_state_s_t        cur;
   rwi_state_s_t        next_cur;
   logic                shared_req;
   logic                wake_req;
   logic                any_req;
   rwi_pkg::rwi_class_t req_cls;
   logic                load;
   logic [7:0]          lat_q;
   logic [7:0]          dir_q;
   logic [7:0]          flag_q;
   logic [7:0]          cfg_q;
   logic [7:0]          hi_en;
   logic [7:0]          latdir_mask;
   logic [7:0]          pin_mask;
   logic [3:0]          irq_set;
   logic                wr_lat;
   logic                wr_dir;
   logic                wr_flag;
   logic                wr_cfg;

   assign shared_req = master_clear_pin_rst | watchdog_timer_rst
                     | instr_rst | stack_rst;
   assign wake_req   = wake_watchdog_timer | wake_irq;
   assign any_req    = bor_rst | shared_req | wake_req;
   assign load       = (cur.st == rwi_pkg::ST_LOAD);

   // Heavier causes win when several arrive together
   always_comb begin
      if (bor_rst) begin
         req_cls = rwi_pkg::CLS_POR; // RQ1
      end else if (shared_req) begin
         req_cls = rwi_pkg::CLS_SHARED; // RQ1
      end else if (wake_req) begin
         req_cls = rwi_pkg::CLS_WAKE; // RQ1
      end else begin
         req_cls = rwi_pkg::CLS_NONE;
      end
   end

   // Upper pins exist only as the oscillator and master-clear allow
   assign hi_en       = cfg_q[rwi_pkg::CFG_FREE67] ? rwi_pkg::MASK_B67
                                                   : 8'h00; // RQ7
   assign latdir_mask = rwi_pkg::LATDIR_IMPL & (rwi_pkg::PORT_LOW_IMPL
                                                | hi_en); // RQ7
   assign pin_mask    = rwi_pkg::PORT_LOW_IMPL | hi_en
                      | (cfg_q[rwi_pkg::CFG_MASTER_CLEAR_PIN_OFF] ? rwi_pkg::MASK_B5
                                                      : 8'h00); // RQ8

   assign wr_lat  = reg_wr && (reg_addr == rwi_pkg::OFF_LAT);
   assign wr_dir  = reg_wr && (reg_addr == rwi_pkg::OFF_DIR);
   assign wr_flag = reg_wr && (reg_addr == rwi_pkg::OFF_FLAG);
   assign wr_cfg  = reg_wr && (reg_addr == rwi_pkg::OFF_CFG);

   rwi_init_cell #(
      .POR_VAL     (rwi_pkg::LAT_POR),
      .SHARED_VAL  (rwi_pkg::LAT_POR),
      .SHARED_KEEP (1'b1),
      .IMPL        (rwi_pkg::LATDIR_IMPL)
   ) u_lat (
      .ref_clk  (ref_clk),
      .arst_n   (arst_n),
      .load     (load),
      .cls      (cur.cls),
      .wr       (wr_lat),
      .wdata    (reg_wdata[7:0]),
      .set_bits (8'h00),
      .q        (lat_q)
   );

   rwi_init_cell #(
      .POR_VAL     (rwi_pkg::DIR_RST),
      .SHARED_VAL  (rwi_pkg::DIR_RST),
      .SHARED_KEEP (1'b0),
      .IMPL        (rwi_pkg::LATDIR_IMPL)
   ) u_dir (
      .ref_clk  (ref_clk),
      .arst_n   (arst_n),
      .load     (load),
      .cls      (cur.cls),
      .wr       (wr_dir),
      .wdata    (reg_wdata[7:0]),
      .set_bits (8'h00),
      .q        (dir_q)
   );

   rwi_init_cell #(
      .POR_VAL     (rwi_pkg::FLAG_RST),
      .SHARED_VAL  (rwi_pkg::FLAG_RST),
      .SHARED_KEEP (1'b0),
      .IMPL        (rwi_pkg::FLAG_IMPL)
   ) u_flag (
      .ref_clk  (ref_clk),
      .arst_n   (arst_n),
      .load     (load),
      .cls      (cur.cls),
      .wr       (wr_flag),
      .wdata    (reg_wdata[7:0]),
      .set_bits (cur.src),
      .q        (flag_q)
   );

   // Configuration survives everything except power-on and brown-out
   rwi_init_cell #(
      .POR_VAL     (rwi_pkg::CFG_POR),
      .SHARED_VAL  (rwi_pkg::CFG_POR),
      .SHARED_KEEP (1'b1),
      .IMPL        (rwi_pkg::CFG_IMPL)
   ) u_cfg (
      .ref_clk  (ref_clk),
      .arst_n   (arst_n),
      .load     (load),
      .cls      (cur.cls),
      .wr       (wr_cfg),
      .wdata    (reg_wdata[7:0]),
      .set_bits (8'h00),
      .q        (cfg_q)
   );

   always_comb begin
      next_cur         = cur;
      next_cur.pc_load = 1'b0;
      irq_set          = 4'h0;
      if (load) begin
         case (cur.cls)
            rwi_pkg::CLS_POR: begin
               next_cur.sp  = rwi_pkg::SP_RST;
               next_cur.tos = rwi_pkg::TOS_POR;
               irq_set[rwi_pkg::IRQ_POR] = 1'b1;
            end
            rwi_pkg::CLS_SHARED: begin
               next_cur.sp = rwi_pkg::SP_RST;
               irq_set[rwi_pkg::IRQ_SHARED] = 1'b1;
            end
            rwi_pkg::CLS_WAKE: begin
               irq_set[rwi_pkg::IRQ_WAKE] = 1'b1;
               if (cur.vec_go) begin
                  next_cur.pc_load   = 1'b1; // RQ5
                  next_cur.pc_vector = cur.vec_low ? rwi_pkg::VEC_LOW
                                                   : rwi_pkg::VEC_HIGH;
                  next_cur.tos       = cur.pc_cap; // RQ6
                  if (cur.sp != rwi_pkg::SP_MAX) begin
                     next_cur.sp = cur.sp + rwi_pkg::SP_ONE; // RQ6
                  end
                  irq_set[rwi_pkg::IRQ_VECTOR] = 1'b1;
               end
            end
            default: begin
               next_cur.sp = cur.sp;
            end
         endcase
         next_cur.st = rwi_pkg::ST_RUN; // RQ9
      end
      // A new cause holds fetch off and is loaded on the next cycle
      if (any_req) begin
         next_cur.st      = rwi_pkg::ST_LOAD; // RQ9
         next_cur.cls     = req_cls;
         next_cur.vec_go  = wake_irq && !bor_rst && !shared_req
                            && (high_priority_global_irq_enable
                                || low_priority_global_irq_enable); // RQ5
         next_cur.vec_low = wake_irq_low;
         next_cur.pc_cap  = pc_in;
         next_cur.src     = wake_src; // RQ4
      end
      if (reg_wr && (reg_addr == rwi_pkg::OFF_IRQ_MASK)) begin
         next_cur.irq_mask = reg_wdata[3:0];
      end
      // A set arriving with its write-one clear still wins
      if (reg_wr && (reg_addr == rwi_pkg::OFF_IRQ_STAT)) begin
         next_cur.irq_stat = (cur.irq_stat & ~reg_wdata[3:0]) | irq_set;
      end else begin
         next_cur.irq_stat = cur.irq_stat | irq_set;
      end
      next_cur.rdata = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            rwi_pkg::OFF_CAUSE:    next_cur.rdata[1:0] = cur.cls;
            rwi_pkg::OFF_LAT:      next_cur.rdata[7:0] = lat_q & latdir_mask;
            rwi_pkg::OFF_DIR:      next_cur.rdata[7:0] = dir_q & latdir_mask;
            rwi_pkg::OFF_PINS:     next_cur.rdata[7:0] = first_port_pins
                                                         & pin_mask; // RQ3
            rwi_pkg::OFF_CFG:      next_cur.rdata[7:0] = cfg_q;
            rwi_pkg::OFF_FLAG:     next_cur.rdata[7:0] = flag_q;
            rwi_pkg::OFF_IRQ_STAT: next_cur.rdata[3:0] = cur.irq_stat;
            rwi_pkg::OFF_IRQ_MASK: next_cur.rdata[3:0] = cur.irq_mask;
            rwi_pkg::OFF_TOS:      next_cur.rdata[20:0] = cur.tos;
            rwi_pkg::OFF_RETURN_STACK_POINTER:   next_cur.rdata[4:0] = cur.sp;
            default:               next_cur.rdata = 32'h0000_0000;
         endcase
      end
   end

   // Power-up starts in the load state so fetch waits for the values
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cur.st        <= rwi_pkg::ST_LOAD; // RQ9
         cur.cls       <= rwi_pkg::CLS_POR;
         cur.vec_go    <= 1'b0;
         cur.vec_low   <= 1'b0;
         cur.pc_cap    <= rwi_pkg::TOS_POR;
         cur.src       <= 8'h00;
         cur.tos       <= rwi_pkg::TOS_POR;
         cur.sp        <= rwi_pkg::SP_RST;
         cur.pc_load   <= 1'b0;
         cur.pc_vector <= rwi_pkg::VEC_HIGH;
         cur.irq_stat  <= 4'h0;
         cur.irq_mask  <= 4'h0;
         cur.rdata     <= 32'h0000_0000;
      end else begin
         cur <= next_cur;
      end
   end

   assign reg_rdata               = cur.rdata;
   assign fetch_en                = (cur.st == rwi_pkg::ST_RUN); // RQ9
   assign pc_load                 = cur.pc_load;
   assign pc_vector               = cur.pc_vector;
   assign return_stack_pointer    = cur.sp;
   assign first_port_output_latch = lat_q & latdir_mask; // RQ7
   assign first_port_direction    = dir_q & latdir_mask; // RQ7
   assign irq                     = |(cur.irq_stat & cur.irq_mask);

   property p_fetch_held;
      @(posedge ref_clk) disable iff (!arst_n)
      any_req |=> !fetch_en ##1 (fetch_en || $past(any_req));
   endproperty
   a_fetch_held: assert property (p_fetch_held) // RQ9
      else $error("fetch not held for one load cycle");

   property p_por_values;
      @(posedge ref_clk) disable iff (!arst_n)
      (load && cur.cls == rwi_pkg::CLS_POR) |=>
         lat_q == rwi_pkg::LAT_POR && dir_q == rwi_pkg::DIR_RST
         && flag_q == rwi_pkg::FLAG_RST && cur.sp == rwi_pkg::SP_RST;
   endproperty
   a_por_values: assert property (p_por_values) // RQ1
      else $error("power-on value set not loaded");

   property p_shared_values;
      @(posedge ref_clk) disable iff (!arst_n)
      (load && cur.cls == rwi_pkg::CLS_SHARED && !reg_wr) |=>
         dir_q == rwi_pkg::DIR_RST && lat_q == $past(lat_q)
         && cfg_q == $past(cfg_q) && cur.sp == rwi_pkg::SP_RST;
   endproperty
   a_shared_values: assert property (p_shared_values) // RQ1
      else $error("shared reset value set wrong");

   property p_wake_keeps;
      @(posedge ref_clk) disable iff (!arst_n)
      (load && cur.cls == rwi_pkg::CLS_WAKE && !reg_wr) |=>
         dir_q == $past(dir_q) && lat_q == $past(lat_q)
         && cfg_q == $past(cfg_q);
   endproperty
   a_wake_keeps: assert property (p_wake_keeps) // RQ2
      else $error("wake-up changed a kept register");

   property p_unimpl_zero;
      @(posedge ref_clk) disable iff (!arst_n)
      (reg_rd && (reg_addr == rwi_pkg::OFF_LAT
                  || reg_addr == rwi_pkg::OFF_DIR)) |=>
         reg_rdata[5] == 1'b0 && reg_rdata[31:8] == 24'h000000;
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero) // RQ3
      else $error("unimplemented bit read as one");

   property p_wake_flag;
      @(posedge ref_clk) disable iff (!arst_n)
      (load && cur.cls == rwi_pkg::CLS_WAKE && !wr_flag) |=>
         ((flag_q & $past(cur.src)) == ($past(cur.src)
                                        & rwi_pkg::FLAG_IMPL));
   endproperty
   a_wake_flag: assert property (p_wake_flag) // RQ4
      else $error("wake source flag not set");

   property p_vector;
      @(posedge ref_clk) disable iff (!arst_n)
      (wake_irq && !bor_rst && !shared_req && wake_irq_low
       && low_priority_global_irq_enable) |=>
         !pc_load ##1 (pc_load && pc_vector == rwi_pkg::VEC_LOW
                       && fetch_en) || $past(any_req);
   endproperty
   a_vector: assert property (p_vector) // RQ5
      else $error("low priority vector not loaded");

   property p_push;
      @(posedge ref_clk) disable iff (!arst_n)
      (load && cur.cls == rwi_pkg::CLS_WAKE && cur.vec_go
       && cur.sp != rwi_pkg::SP_MAX) |=>
         cur.sp == $past(cur.sp) + rwi_pkg::SP_ONE
         && cur.tos == $past(cur.pc_cap);
   endproperty
   a_push: assert property (p_push) // RQ6
      else $error("program counter not pushed");

   property p_hi_bits;
      @(posedge ref_clk) disable iff (!arst_n)
      !cfg_q[rwi_pkg::CFG_FREE67] |->
         (first_port_output_latch & rwi_pkg::MASK_B67) == 8'h00
         && (first_port_direction & rwi_pkg::MASK_B67) == 8'h00;
   endproperty
   a_hi_bits: assert property (p_hi_bits) // RQ7
      else $error("port bits 6 or 7 visible while not freed");

   property p_bit5_pin;
      @(posedge ref_clk) disable iff (!arst_n)
      (reg_rd && reg_addr == rwi_pkg::OFF_PINS
       && !cfg_q[rwi_pkg::CFG_MASTER_CLEAR_PIN_OFF]) |=> reg_rdata[5] == 1'b0;
   endproperty
   a_bit5_pin: assert property (p_bit5_pin) // RQ8
      else $error("port bit 5 read while master clear active");

   c_wake_vector: cover property (@(posedge ref_clk) disable iff (!arst_n)
      pc_load && pc_vector == rwi_pkg::VEC_HIGH);
   c_shared_reset: cover property (@(posedge ref_clk) disable iff (!arst_n)
      load && cur.cls == rwi_pkg::CLS_SHARED);
   c_wake_plain: cover property (@(posedge ref_clk) disable iff (!arst_n)
      load && cur.cls == rwi_pkg::CLS_WAKE && !cur.vec_go);
   c_irq: cover property (@(posedge ref_clk) disable iff (!arst_n) irq);

endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the reset and wake-up initialiser.
// Assumes the design carries its own assertions; the bench drives all ports.
`timescale 1ns/10ps
module tb_top;
   typedef struct {
      logic        do_wr;
      logic [5:0]  waddr;
      logic [31:0] wdata;
      logic [5:0]  raddr;
      logic [31:0] exp;
   } rwi_tb_row_t;

   logic        ref_clk, arst_n, bor_rst, master_clear_pin_rst;
   logic        watchdog_timer_rst, instr_rst, stack_rst;
   logic        wake_watchdog_timer, wake_irq, wake_irq_low;
   logic [7:0]  wake_src, first_port_pins;
   logic        high_priority_global_irq_enable;
   logic        low_priority_global_irq_enable;
   logic [20:0] pc_in, pc_vector;
   logic [5:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic        reg_wr, reg_rd, fetch_en, pc_load, irq;
   logic [4:0]  return_stack_pointer;
   logic [7:0]  first_port_output_latch, first_port_direction;
   int          fail_count;
   int          comparisons;

   // Rows run in order: each builds on the configuration left by the last
   rwi_tb_row_t rows [0:11] = '{
      '{1'b0, 6'h00, 32'h0, rwi_pkg::OFF_CAUSE, 32'h1},
      '{1'b1, rwi_pkg::OFF_LAT, 32'hff, rwi_pkg::OFF_LAT, 32'h1f},
      '{1'b1, rwi_pkg::OFF_DIR, 32'h00, rwi_pkg::OFF_DIR, 32'h00},
      '{1'b1, rwi_pkg::OFF_CFG, 32'hff, rwi_pkg::OFF_CFG, 32'h03},
      '{1'b1, rwi_pkg::OFF_LAT, 32'hff, rwi_pkg::OFF_LAT, 32'hdf},
      '{1'b1, rwi_pkg::OFF_DIR, 32'hff, rwi_pkg::OFF_DIR, 32'hdf},
      '{1'b0, 6'h00, 32'h0, rwi_pkg::OFF_PINS, 32'hff},
      '{1'b1, rwi_pkg::OFF_CFG, 32'h01, rwi_pkg::OFF_PINS, 32'hdf},
      '{1'b1, rwi_pkg::OFF_CFG, 32'h02, rwi_pkg::OFF_PINS, 32'h3f},
      '{1'b1, 6'h3c, 32'hffffffff, 6'h3c, 32'h0},
      '{1'b1, rwi_pkg::OFF_FLAG, 32'hff, rwi_pkg::OFF_FLAG, 32'h77},
      '{1'b1, rwi_pkg::OFF_CFG, 32'h00, rwi_pkg::OFF_LAT, 32'h1f}
   };

   rwi_reset_init rwi_reset_init_inst (
      .ref_clk, .arst_n, .bor_rst, .master_clear_pin_rst,
      .watchdog_timer_rst, .instr_rst, .stack_rst, .wake_watchdog_timer,
      .wake_irq, .wake_irq_low, .wake_src, .high_priority_global_irq_enable,
      .low_priority_global_irq_enable, .pc_in, .first_port_pins, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fetch_en, .pc_load,
      .pc_vector, .return_stack_pointer, .first_port_output_latch,
      .first_port_direction, .irq
   );

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic close_out;
      if (fail_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk_out(input string nm, input logic [31:0] exp,
                          input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic reg_write(input logic [5:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic chk_rd(input logic [5:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      chk_out($sformatf("reg_rdata at %h", a), exp, reg_rdata);
   endtask

   task automatic req(input int k);
      @(posedge ref_clk);
      case (k)
         0: bor_rst <= 1'b1;
         1: master_clear_pin_rst <= 1'b1;
         2: watchdog_timer_rst <= 1'b1;
         3: instr_rst <= 1'b1;
         4: stack_rst <= 1'b1;
         6: {bor_rst, stack_rst} <= 2'b11;
         7: {stack_rst, wake_watchdog_timer} <= 2'b11;
         default: wake_watchdog_timer <= 1'b1;
      endcase
      @(posedge ref_clk);
      {bor_rst, master_clear_pin_rst, watchdog_timer_rst} <= 3'b000;
      {instr_rst, stack_rst, wake_watchdog_timer} <= 3'b000;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic do_reset;
      @(posedge ref_clk);
      arst_n <= 1'b0;
      repeat (10) @(posedge ref_clk);
      @(negedge ref_clk);
      chk_out("fetch_en", 32'h0, fetch_en);
      chk_out("latch", 32'h00, first_port_output_latch);
      chk_out("direction", 32'h1f, first_port_direction);
      chk_out("stack pointer", 32'h0, return_stack_pointer);
      @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk_out("fetch_en", 32'h1, fetch_en);
   endtask

   task automatic irq_wake(input logic lo, input logic gh, input logic gl,
                           input logic [20:0] pc, input logic [31:0] ld,
                           input logic [31:0] vec, input logic [31:0] sp,
                           input logic [31:0] tos);
      @(posedge ref_clk);
      wake_irq <= 1'b1;
      wake_irq_low <= lo;
      high_priority_global_irq_enable <= gh;
      low_priority_global_irq_enable <= gl;
      pc_in <= pc;
      @(posedge ref_clk);
      wake_irq <= 1'b0;
      @(negedge ref_clk);
      chk_out("fetch_en in load", 32'h0, fetch_en);
      @(negedge ref_clk);
      chk_out("fetch_en after load", 32'h1, fetch_en);
      chk_out("pc_load", ld, pc_load);
      if (ld[0])
         chk_out("pc_vector", vec, pc_vector);
      chk_out("stack pointer", sp, return_stack_pointer);
      chk_rd(rwi_pkg::OFF_TOS, tos);
      chk_rd(rwi_pkg::OFF_RETURN_STACK_POINTER, sp);
   endtask

   initial begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      close_out();
   end

   initial begin
      fail_count = 0;
      comparisons = 0;
      {arst_n, bor_rst, master_clear_pin_rst, watchdog_timer_rst} = 4'h0;
      {instr_rst, stack_rst, wake_watchdog_timer, wake_irq} = 4'h0;
      {wake_irq_low, reg_wr, reg_rd} = 3'h0;
      high_priority_global_irq_enable = 1'b0;
      low_priority_global_irq_enable = 1'b0;
      wake_src = 8'h00;
      first_port_pins = 8'hff;
      pc_in = 21'h000000;
      reg_addr = 6'h00;
      reg_wdata = 32'h0;
      do_reset();
      foreach (rows[i]) begin
         if (rows[i].do_wr)
            reg_write(rows[i].waddr, rows[i].wdata);
         chk_rd(rows[i].raddr, rows[i].exp);
      end
      // Interrupt: raise from power-on status, mask, clear
      chk_rd(rwi_pkg::OFF_IRQ_STAT, 32'h1);
      chk_out("irq masked", 32'h0, irq);
      reg_write(rwi_pkg::OFF_IRQ_MASK, 32'hf);
      @(negedge ref_clk);
      chk_out("irq unmasked", 32'h1, irq);
      reg_write(rwi_pkg::OFF_IRQ_STAT, 32'hf);
      @(negedge ref_clk);
      chk_out("irq cleared", 32'h0, irq);
      reg_write(rwi_pkg::OFF_LAT, 32'h0a);
      for (int k = 1; k <= 4; k++) begin
         reg_write(rwi_pkg::OFF_DIR, 32'h05);
         reg_write(rwi_pkg::OFF_FLAG, 32'h11);
         req(k);
         chk_rd(rwi_pkg::OFF_CAUSE, 32'h2);
         chk_rd(rwi_pkg::OFF_LAT, 32'h0a);
         chk_rd(rwi_pkg::OFF_DIR, 32'h1f);
         chk_rd(rwi_pkg::OFF_FLAG, 32'h0);
         chk_out("irq shared", 32'h1, irq);
         reg_write(rwi_pkg::OFF_IRQ_STAT, 32'hf);
      end
      // Watchdog wake keeps contents, sets source flags and the wake status bit
      reg_write(rwi_pkg::OFF_DIR, 32'h05);
      wake_src <= 8'h05;
      req(5);
      chk_rd(rwi_pkg::OFF_CAUSE, 32'h3);
      chk_rd(rwi_pkg::OFF_DIR, 32'h05);
      chk_rd(rwi_pkg::OFF_LAT, 32'h0a);
      chk_rd(rwi_pkg::OFF_FLAG, 32'h05);
      chk_rd(rwi_pkg::OFF_IRQ_STAT, 32'h4);
      chk_out("stack pointer", 32'h0, return_stack_pointer);
      reg_write(rwi_pkg::OFF_IRQ_STAT, 32'hf);
      wake_src <= 8'h40;
      irq_wake(1'b0, 1'b1, 1'b0, 21'h012345, 1, 32'h8, 1, 32'h12345);
      chk_rd(rwi_pkg::OFF_FLAG, 32'h45);
      chk_rd(rwi_pkg::OFF_IRQ_STAT, 32'hc);
      irq_wake(1'b1, 1'b0, 1'b1, 21'h00abcd, 1, 32'h18, 2, 32'habcd);
      // No global enable: no vector, no push
      irq_wake(1'b0, 1'b0, 1'b0, 21'h001111, 0, 32'h0, 2, 32'habcd);
      chk_rd(rwi_pkg::OFF_DIR, 32'h05);
      reg_write(rwi_pkg::OFF_CFG, 32'h3);
      req(0);
      chk_rd(rwi_pkg::OFF_CAUSE, 32'h1);
      chk_rd(rwi_pkg::OFF_CFG, 32'h0);
      chk_rd(rwi_pkg::OFF_LAT, 32'h0);
      chk_out("stack pointer", 32'h0, return_stack_pointer);
      reg_write(rwi_pkg::OFF_CFG, 32'h3);
      do_reset();
      chk_rd(rwi_pkg::OFF_CFG, 32'h0);
      // Heavier cause wins when two arrive together
      req(7);
      chk_rd(rwi_pkg::OFF_CAUSE, 32'h2);
      req(6);
      chk_rd(rwi_pkg::OFF_CAUSE, 32'h1);
      // A clear landing on the load edge loses to the new status bit
      fork
         req(1);
         begin
            @(posedge ref_clk);
            reg_write(rwi_pkg::OFF_IRQ_STAT, 32'hf);
         end
      join
      chk_rd(rwi_pkg::OFF_IRQ_STAT, 32'h2);
      close_out();
   end
endmodule
